// File: usr_pkg.sv
// Purpose: shared constants and types of the eight-bit universal register
// Assumes: one 100 MHz clock, classic Wishbone slave for software access
// Notes: offsets are byte addresses of aligned 32-bit words

package usr_pkg;

  // ------------------------------------------------------------
  // widths and timing
  // ------------------------------------------------------------
  localparam int W = 8;
  localparam int CLK_MHZ = 100;
  localparam int SHIFT_MAX_MHZ = 50;
  // whole clock cycles per shift needed to honour the maximum rate
  localparam int SHIFT_MIN_CYC = (CLK_MHZ + SHIFT_MAX_MHZ - 1) / SHIFT_MAX_MHZ;

  // ------------------------------------------------------------
  // register map
  // ------------------------------------------------------------
  localparam logic [7:0] ADR_CTRL = 8'h00;
  localparam logic [7:0] ADR_DATA = 8'h04;
  localparam logic [7:0] ADR_STAT = 8'h08;
  localparam logic [3:0] CTRL_RST = 4'h0;
  localparam int CTRL_USE_SW = 0;
  localparam int CTRL_SEL_LO = 1;
  localparam int CTRL_SEL_HI = 2;
  localparam int CTRL_OFF = 3;
  localparam int STAT_DRV = 4;
  localparam int STAT_CLR = 5;

  // ------------------------------------------------------------
  // modes
  // ------------------------------------------------------------
  typedef enum logic [3:0] {
    MODE_HOLD = 4'h1,
    MODE_SHR = 4'h2,
    MODE_SHL = 4'h4,
    MODE_LOAD = 4'h8
  } usr_mode_t;

endpackage : usr_pkg

// File: usr_core_if.sv
// Purpose: carrier between the top and the storage core
// Assumes: all signals on clk_i
// Notes: q is the live register content
`timescale 1ns/1ns
interface usr_core_if;
  usr_pkg::usr_mode_t mode;
  logic right_in;
  logic left_in;
  logic [usr_pkg::W-1:0] load_data;
  logic [usr_pkg::W-1:0] q;
  modport core (input mode, input right_in, input left_in,
                input load_data, output q);
  modport ctl (output mode, output right_in, output left_in,
               output load_data, input q);
endinterface : usr_core_if

// File: usr_sync.sv
// Purpose: two-flop synchroniser for pin inputs
// Assumes: inputs asynchronous to clk_i
// Notes: first stage is read only by the second
`timescale 1ns/1ns
module usr_sync #(
  parameter int SW = 1
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [SW-1:0] d_i,
  output logic [SW-1:0] q_o
);
  logic [SW-1:0] meta_r;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_r <= '0;
      q_o <= '0;
    end else begin
      meta_r <= d_i;
      q_o <= meta_r;
    end
  end
endmodule : usr_sync

// File: usr_core.sv
// Purpose: eight storage stages with shift and parallel load
// Assumes: mode and data already in clk_i domain
// Notes: clear_n_i acts without the clock
`timescale 1ns/1ns
module usr_core (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic clear_n_i,
  usr_core_if.core cif
);
  logic [usr_pkg::W-1:0] q_r;
  logic [usr_pkg::W-1:0] q_nxt;

  // ------------------------------------------------------------
  // per-stage next value
  // ------------------------------------------------------------
  for (genvar i = 0; i < usr_pkg::W; i++) begin : g_bit
    logic from_lo;
    logic from_hi;
    if (i == 0) begin : g_first
      assign from_lo = cif.right_in;
    end else begin : g_mid_lo
      assign from_lo = q_r[i-1];
    end
    if (i == usr_pkg::W - 1) begin : g_last
      assign from_hi = cif.left_in;
    end else begin : g_mid_hi
      assign from_hi = q_r[i+1];
    end
    always_comb begin
      unique case (cif.mode)
        usr_pkg::MODE_HOLD: q_nxt[i] = q_r[i];
        usr_pkg::MODE_SHR: q_nxt[i] = from_lo;
        usr_pkg::MODE_SHL: q_nxt[i] = from_hi;
        usr_pkg::MODE_LOAD: q_nxt[i] = cif.load_data[i];
        default: q_nxt[i] = q_r[i];
      endcase
    end
  end

  // one step per edge, above the guaranteed shift rate
  always_ff @(posedge clk_i or negedge clear_n_i) begin
    if (!clear_n_i) begin
      q_r <= '0;
    end else if (rst_i) begin
      q_r <= '0;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign cif.q = q_r;
endmodule : usr_core

// File: usr_top.sv
// Purpose: universal shift/storage register with Wishbone access
// Assumes: pins asynchronous, synchronised two flops deep, except clear_n_i, which reaches the core directly
// Notes: software may take over the mode and force drivers off
//
// Register access over Wishbone and the placing of the registers were left to the implementer.
`timescale 1ns/1ns
module usr_top (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic clear_n_i,
  input wire logic mode_sel_lo_i,
  input wire logic mode_sel_hi_i,
  input wire logic out_disable_one_i,
  input wire logic out_disable_two_i,
  input wire logic left_serial_in_i,
  input wire logic right_serial_in_i,
  input wire logic [7:0] bidir_data_lines_i,
  output logic [7:0] bidir_data_lines_o,
  output logic [7:0] bidir_data_lines_oe_o,
  output logic first_stage_tap_o,
  output logic last_stage_tap_o,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o
);

  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  logic [7:0] data_s;
  logic [5:0] ctl_s;
  logic sel_lo_s;
  logic sel_hi_s;
  logic dis1_s;
  logic dis2_s;
  logic sl_s;
  logic sr_s;
  logic clr_s;

  // external party keeps these steady around edges; sync guards metastability
  usr_sync #(.SW(8)) u_sync_data (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i(bidir_data_lines_i),
    .q_o(data_s)
  );

  usr_sync #(.SW(6)) u_sync_ctl (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i({mode_sel_hi_i, mode_sel_lo_i, out_disable_two_i,
          out_disable_one_i, left_serial_in_i, right_serial_in_i}),
    .q_o(ctl_s)
  );

  usr_sync #(.SW(1)) u_sync_clr (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i(clear_n_i),
    .q_o(clr_s)
  );

  assign sel_hi_s = ctl_s[5];
  assign sel_lo_s = ctl_s[4];
  assign dis2_s = ctl_s[3];
  assign dis1_s = ctl_s[2];
  assign sl_s = ctl_s[1];
  assign sr_s = ctl_s[0];

  // ------------------------------------------------------------
  // wishbone slave
  // ------------------------------------------------------------
  logic [3:0] ctrl_r;
  logic ack_r;
  logic [31:0] rdat_r;
  logic req;
  logic drive_en;
  logic [31:0] rdat_nxt;

  usr_core_if cif ();

  assign req = wb_cyc_i && wb_stb_i;

  // ack one cycle after request, dropped in the following cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= req && !ack_r;
    end
  end

  // write lands on the edge at which the master sees ack
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_r <= usr_pkg::CTRL_RST;
    end else if (req && ack_r && wb_we_i && wb_sel_i[0] &&
                 wb_adr_i == usr_pkg::ADR_CTRL) begin
      ctrl_r <= wb_dat_i[3:0];
    end
  end

  always_comb begin
    rdat_nxt = 32'h0;
    unique case (wb_adr_i)
      usr_pkg::ADR_CTRL: rdat_nxt[3:0] = ctrl_r;
      usr_pkg::ADR_DATA: rdat_nxt[7:0] = cif.q;
      usr_pkg::ADR_STAT: begin
        rdat_nxt[3:0] = cif.mode;
        rdat_nxt[usr_pkg::STAT_DRV] = drive_en;
        rdat_nxt[usr_pkg::STAT_CLR] = clr_s;
      end
      default: rdat_nxt = 32'h0;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdat_r <= 32'h0;
    end else if (req && !ack_r) begin
      rdat_r <= rdat_nxt;
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = rdat_r;

  // ------------------------------------------------------------
  // mode decode
  // ------------------------------------------------------------
  logic eff_lo;
  logic eff_hi;
  usr_pkg::usr_mode_t mode;

  // software override takes ctrl_r directly, without the pins' synchroniser latency
  assign eff_lo = ctrl_r[usr_pkg::CTRL_USE_SW] ?
                  ctrl_r[usr_pkg::CTRL_SEL_LO] : sel_lo_s;
  assign eff_hi = ctrl_r[usr_pkg::CTRL_USE_SW] ?
                  ctrl_r[usr_pkg::CTRL_SEL_HI] : sel_hi_s;

  always_comb begin
    unique case ({eff_hi, eff_lo})
      2'h0: mode = usr_pkg::MODE_HOLD;
      2'h1: mode = usr_pkg::MODE_SHR;
      2'h2: mode = usr_pkg::MODE_SHL;
      2'h3: mode = usr_pkg::MODE_LOAD;
      default: mode = usr_pkg::MODE_HOLD;
    endcase
  end

  // ------------------------------------------------------------
  // storage core
  // ------------------------------------------------------------
  assign cif.mode = mode;
  assign cif.right_in = sr_s;
  assign cif.left_in = sl_s;
  assign cif.load_data = data_s;

  // core never looks at drive_en, so drivers cannot disturb it
  usr_core u_core (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .clear_n_i(clear_n_i),
    .cif(cif)
  );

  // ------------------------------------------------------------
  // line drivers and taps
  // ------------------------------------------------------------
  always_comb begin
    drive_en = 1'b1;
    if (mode == usr_pkg::MODE_LOAD) begin
      drive_en = 1'b0;
    end
    if (dis1_s || dis2_s) begin
      drive_en = 1'b0;
    end
    if (ctrl_r[usr_pkg::CTRL_OFF]) begin
      drive_en = 1'b0;
    end
  end

  assign bidir_data_lines_o = cif.q;
  assign bidir_data_lines_oe_o = {8{drive_en}};
  // taps come straight off stage flops, so clear empties them too
  assign first_stage_tap_o = cif.q[0];
  assign last_stage_tap_o = cif.q[7];

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  sequence s_run(usr_pkg::usr_mode_t m);
    mode == m && clear_n_i;
  endsequence

  sequence s_next_run;
    clear_n_i;
  endsequence

  a_mode_decode: assert property (
    ({eff_hi, eff_lo} == 2'h1) |-> mode == usr_pkg::MODE_SHR
  ) else $error("select low only must choose shift right");

  a_load_capture: assert property (
    s_run(usr_pkg::MODE_LOAD) ##1 s_next_run |-> cif.q == $past(data_s)
  ) else $error("load did not capture the data lines");

  a_load_hiz: assert property (
    mode == usr_pkg::MODE_LOAD |-> bidir_data_lines_oe_o == 8'h00
  ) else $error("drivers on during load");

  a_drive_contents: assert property (
    (mode != usr_pkg::MODE_LOAD && !dis1_s && !dis2_s &&
     !ctrl_r[usr_pkg::CTRL_OFF]) |->
      bidir_data_lines_oe_o == 8'hff && bidir_data_lines_o == cif.q
  ) else $error("enabled drivers not showing contents");

  a_clear_empty: assert property (
    !clear_n_i |-> cif.q == 8'h00 && !first_stage_tap_o && !last_stage_tap_o
  ) else $error("clear did not empty register and taps");

  a_hold_keep: assert property (
    s_run(usr_pkg::MODE_HOLD) ##1 s_next_run |-> $stable(cif.q)
  ) else $error("hold changed the register");

  a_shift_right: assert property (
    s_run(usr_pkg::MODE_SHR) ##1 s_next_run |->
      cif.q == {$past(cif.q[6:0]), $past(sr_s)}
  ) else $error("shift right wrong");

  a_shift_left: assert property (
    s_run(usr_pkg::MODE_SHL) ##1 s_next_run |->
      cif.q == {$past(sl_s), $past(cif.q[7:1])}
  ) else $error("shift left wrong");

  a_shift_run: assert property (
    s_run(usr_pkg::MODE_SHR) ##1 s_run(usr_pkg::MODE_SHR) ##1 clear_n_i
      |-> cif.q[7:2] == $past(cif.q[5:0], 2)
  ) else $error("back to back shifts lost a step");

  a_off_still_loads: assert property (
    s_run(usr_pkg::MODE_LOAD) ##0 dis1_s ##1 s_next_run |->
      cif.q == $past(data_s) && bidir_data_lines_oe_o == 8'h00
  ) else $error("load affected by drivers off");

  a_taps_mirror: assert property (
    first_stage_tap_o == cif.q[0] && last_stage_tap_o == cif.q[7]
  ) else $error("taps do not mirror end stages");

  a_disable_hiz: assert property (
    (dis1_s || dis2_s) |-> bidir_data_lines_oe_o == 8'h00
  ) else $error("output disable ignored");

  a_wb_ack_pulse: assert property (
    wb_ack_o |=> !wb_ack_o
  ) else $error("ack held longer than one cycle");

  a_wb_ack_time: assert property (
    (req && !wb_ack_o) |=> wb_ack_o
  ) else $error("ack not given one cycle after request");

  // ------------------------------------------------------------
  // decode, driver, shift and bus checks
  // ------------------------------------------------------------
  sequence s_take;
    req && !wb_ack_o;
  endsequence

  sequence s_ctrl_wr;
    req && wb_ack_o && wb_we_i && wb_sel_i[0] &&
      wb_adr_i == usr_pkg::ADR_CTRL;
  endsequence

  a_mode_hold_code: assert property (
    ({eff_hi, eff_lo} == 2'h0) |-> mode == usr_pkg::MODE_HOLD
  ) else $error("both selects low must choose hold");

  a_mode_left_code: assert property (
    ({eff_hi, eff_lo} == 2'h2) |-> mode == usr_pkg::MODE_SHL
  ) else $error("select high only must choose shift left");

  a_mode_load_code: assert property (
    ({eff_hi, eff_lo} == 2'h3) |-> mode == usr_pkg::MODE_LOAD
  ) else $error("both selects high must choose load");

  a_mode_onehot: assert property (
    $onehot(mode)
  ) else $error("mode code not one-hot");

  // pins act two edges late; skip edges still inside the reset shadow
  a_pin_latency: assert property (
    (!ctrl_r[usr_pkg::CTRL_USE_SW] && !$past(rst_i) && !$past(rst_i, 2))
      |-> {eff_hi, eff_lo} == $past({mode_sel_hi_i, mode_sel_lo_i}, 2)
  ) else $error("select pins not two edges deep");

  a_sw_select: assert property (
    (ctrl_r[usr_pkg::CTRL_USE_SW] && !ctrl_r[usr_pkg::CTRL_SEL_LO] &&
     !ctrl_r[usr_pkg::CTRL_SEL_HI]) |-> mode == usr_pkg::MODE_HOLD
  ) else $error("software select ignored");

  a_ctrl_off_hiz: assert property (
    ctrl_r[usr_pkg::CTRL_OFF] |-> bidir_data_lines_oe_o == 8'h00
  ) else $error("software driver off ignored");

  a_oe_uniform: assert property (
    bidir_data_lines_oe_o == 8'h00 || bidir_data_lines_oe_o == 8'hff
  ) else $error("line enables split");

  a_shift_left_run: assert property (
    s_run(usr_pkg::MODE_SHL) ##1 s_run(usr_pkg::MODE_SHL) ##1 clear_n_i
      |-> cif.q[5:0] == $past(cif.q[7:2], 2)
  ) else $error("back to back left shifts lost a step");

  a_wb_ctrl_write: assert property (
    s_ctrl_wr |=> ctrl_r == $past(wb_dat_i[3:0])
  ) else $error("control write did not land");

  a_wb_ctrl_keep: assert property (
    !(req && wb_ack_o && wb_we_i) |=> $stable(ctrl_r)
  ) else $error("control changed without a write");

  a_wb_ack_source: assert property (
    wb_ack_o |-> $past(req)
  ) else $error("ack without request");

  a_wb_read_data: assert property (
    s_take ##0 (wb_adr_i == usr_pkg::ADR_DATA) |=>
      wb_dat_o == {24'h0, $past(cif.q)}
  ) else $error("data read not the contents");

  a_wb_unmapped: assert property (
    s_take ##0 (wb_adr_i != usr_pkg::ADR_CTRL &&
                wb_adr_i != usr_pkg::ADR_DATA &&
                wb_adr_i != usr_pkg::ADR_STAT) |=> wb_dat_o == 32'h0
  ) else $error("unmapped read not zero");

  a_wb_stat_drive: assert property (
    s_take ##0 (wb_adr_i == usr_pkg::ADR_STAT) |=>
      wb_dat_o[usr_pkg::STAT_DRV] == $past(drive_en)
  ) else $error("status drive bit wrong");

  a_wb_dat_hold: assert property (
    !(req && !wb_ack_o) |=> $stable(wb_dat_o)
  ) else $error("read data moved between requests");

endmodule : usr_top

// File: usr_bus_agent.sv
// Purpose: far-side bus logic on the eight shared data lines
// Assumes: bench changes drv_en_i and drv_val_i just after clk_i rises
// Notes: released lines show the inverse of the last wire value
`timescale 1ns/1ns
module usr_bus_agent (
  input wire logic clk_i,
  input wire logic drv_en_i,
  input wire logic [7:0] drv_val_i,
  input wire logic [7:0] dev_o_i,
  input wire logic [7:0] dev_oe_i,
  output logic [7:0] lines_o
);
  logic [7:0] alt_r;
  // nobody driving: a changing pattern, never a stale value
  always_ff @(posedge clk_i) begin
    alt_r <= ~lines_o;
  end
  // steady levels only change right after an edge
  always_comb begin
    lines_o = alt_r;
    if (drv_en_i) begin
      lines_o = drv_val_i;
    end
    if (dev_oe_i[0]) begin
      lines_o = dev_o_i;
    end
  end
endmodule : usr_bus_agent

// File: usr_top_tb.sv
// Purpose: self-checking bench for the universal register
// Assumes: pins act two edges after they are sampled
// Notes: wishbone ack is sampled at the edge, no fixed latency assumed
`timescale 1ns/1ns
module usr_top_tb;
  logic clk_i = 1'b0, rst_i = 1'b1, clear_n_i = 1'b1;
  logic sel_lo = 1'b0, sel_hi = 1'b0, dis1 = 1'b0, dis2 = 1'b0;
  logic sl = 1'b0, sr = 1'b0, drv_en = 1'b0;
  logic [7:0] drv_val = 8'h00, lines, d_o, oe;
  logic tap_f, tap_l, cyc = 1'b0, stb = 1'b0, we = 1'b0, ack;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'hf;
  logic [31:0] wdat = 32'h0, rdat, rd;
  int failures = 0, checks_done = 0;
  always #5 clk_i = ~clk_i;
  usr_top u_usr_top (.clk_i(clk_i), .rst_i(rst_i), .clear_n_i(clear_n_i),
    .mode_sel_lo_i(sel_lo), .mode_sel_hi_i(sel_hi),
    .out_disable_one_i(dis1), .out_disable_two_i(dis2),
    .left_serial_in_i(sl), .right_serial_in_i(sr),
    .bidir_data_lines_i(lines), .bidir_data_lines_o(d_o),
    .bidir_data_lines_oe_o(oe), .first_stage_tap_o(tap_f),
    .last_stage_tap_o(tap_l), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack));
  usr_bus_agent u_usr_bus_agent (.clk_i(clk_i), .drv_en_i(drv_en),
    .drv_val_i(drv_val), .dev_o_i(d_o), .dev_oe_i(oe), .lines_o(lines));
  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task close_out;
    $display("checks %0d mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : close_out
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task step(input int n);
    repeat (n) @(posedge clk_i);
  endtask : step
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    // ack is a flop: reading it here gives its value at this edge
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 50);
    rd = rdat;
    if (n >= 50) begin
      failures++;
    end
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask : wb
  // pins held for n sampled edges give exactly n steps
  task mode(input logic [1:0] m, input int n);
    {sel_hi, sel_lo} <= m;
    step(n);
    {sel_hi, sel_lo} <= 2'b00;
    step(4);
  endtask : mode
  initial begin
    #200000;
    failures++;
    close_out();
  end
  // ------------------------------------------------------------
  // tests
  // ------------------------------------------------------------
  initial begin
    step(5);
    rst_i <= 1'b0;
    step(3);
    wb(1'b0, 8'h04, 32'h0);
    chk(rd, 32'h0);
    chk({24'h0, oe}, 32'hff);
    wb(1'b0, 8'h40, 32'h0);
    chk(rd, 32'h0);
    $display("test reset done");
    drv_en <= 1'b1;
    drv_val <= 8'ha5;
    sr <= 1'b1;
    {sel_hi, sel_lo} <= 2'b11;
    step(3);
    chk({24'h0, oe}, 32'h0);
    {sel_hi, sel_lo} <= 2'b00;
    step(4);
    drv_en <= 1'b0;
    chk({24'h0, d_o}, 32'ha5);
    wb(1'b1, 8'h04, 32'h0);
    wb(1'b0, 8'h04, 32'h0);
    chk(rd, 32'ha5);
    step(6);
    chk({24'h0, d_o}, 32'ha5);
    $display("test load done");
    mode(2'b01, 3);
    chk({24'h0, d_o}, 32'h2f);
    chk({30'h0, tap_l, tap_f}, 32'h1);
    mode(2'b10, 2);
    chk({24'h0, d_o}, 32'h0b);
    $display("test shift done");
    dis1 <= 1'b1;
    sl <= 1'b1;
    step(3);
    chk({24'h0, oe}, 32'h0);
    mode(2'b10, 1);
    wb(1'b0, 8'h04, 32'h0);
    chk(rd, 32'h85);
    drv_en <= 1'b1;
    drv_val <= 8'h3c;
    mode(2'b11, 2);
    drv_en <= 1'b0;
    wb(1'b0, 8'h04, 32'h0);
    chk(rd, 32'h3c);
    dis1 <= 1'b0;
    dis2 <= 1'b1;
    step(3);
    chk({24'h0, oe}, 32'h0);
    @(posedge clk_i);
    clear_n_i <= 1'b0;
    #1;
    chk({22'h0, tap_l, tap_f, d_o}, 32'h0);
    @(posedge clk_i);
    clear_n_i <= 1'b1;
    dis2 <= 1'b0;
    $display("test disable clear done");
    {sel_hi, sel_lo} <= 2'b11;
    wb(1'b1, 8'h00, 32'h9);
    wb(1'b0, 8'h00, 32'h0);
    chk(rd, 32'h9);
    chk({24'h0, oe}, 32'h0);
    wb(1'b0, 8'h08, 32'h0);
    chk({28'h0, rd[3:0]}, 32'h1);
    wb(1'b1, 8'h00, 32'h0);
    for (int m = 0; m < 4; m++) begin
      {sel_hi, sel_lo} <= m[1:0];
      step(4);
      wb(1'b0, 8'h08, 32'h0);
      chk({27'h0, rd[4:0]}, {27'h0, m != 3, 4'h1 << m});
    end
    $display("test modes done");
    close_out();
  end
endmodule : usr_top_tb
